// file: rtl/fepc_top.sv
// Flash erase/program controller: registers, protection and sequencer
`timescale 1ns/1ps
`include "fepc_regs.svh"
module fepc_top
  import fepc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cpu_only_reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fl_wr,
  input wire logic fl_rd,
  input wire logic [31:0] fl_addr,
  input wire logic [31:0] fl_wdata,
  input wire logic [1:0] fl_size,
  output logic [31:0] fl_rdata,
  input wire logic [31:0] cpu_pc,
  input wire logic user_option_word_boot,
  input wire logic [31:0] cfg_sector_erase_time,
  input wire logic [31:0] cfg_whole_erase_time,
  input wire logic [31:0] cfg_program_time,
  input wire logic [31:0] arr_rdata,
  output logic arr_prog,
  output logic arr_sector_erase,
  output logic arr_whole_erase,
  output logic arr_system_region,
  output logic [31:0] arr_addr,
  output logic [31:0] arr_wdata,
  output logic [1:0] arr_size,
  output logic fetch_hold,
  output logic boot_loader_select_bit,
  output logic irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  fepc_op_e operation_select;
  logic [1:0] alarm_irq_enables;
  logic busy;
  logic pc_alarm_flag;
  logic lock_alarm_flag;
  logic [31:0] lock_bits_low;
  logic [31:0] lock_bits_high;
  logic [31:0] sector_erase_time;
  logic [31:0] whole_erase_time;
  logic [31:0] program_time;
  logic cold_load;
  fepc_unlock_e unl_state;
  fepc_seq_e seq_state;
  logic soft_rst;
  logic timer_start;
  logic timer_active;
  logic timer_done;
  logic [31:0] timer_len;

  // CPU-only reset clears control state but not boot select or timings
  assign soft_rst = rst || cpu_only_reset;

  // ----------------------------------------------------------------------
  // Register write decode and unlock gating
  // ----------------------------------------------------------------------
  logic hit_unlock;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_lock_lo;
  logic wr_lock_hi;
  logic wr_boot;
  logic wr_t_se;
  logic wr_t_we;
  logic wr_t_pg;

  assign hit_unlock = reg_addr == `FEPC_OFS_UNLOCK;
  // Only the one write after a full unlock reaches a register
  assign wr_ok = reg_wr && !hit_unlock && unl_state == FEPC_UNL_OPEN;
  assign wr_ctrl = wr_ok && reg_addr == `FEPC_OFS_CONTROL;
  assign wr_clear = wr_ok && reg_addr == `FEPC_OFS_CLEAR;
  assign wr_lock_lo = wr_ok && reg_addr == `FEPC_OFS_LOCK_LO;
  assign wr_lock_hi = wr_ok && reg_addr == `FEPC_OFS_LOCK_HI;
  assign wr_boot = wr_ok && reg_addr == `FEPC_OFS_BOOT;
  assign wr_t_se = wr_ok && reg_addr == `FEPC_OFS_T_SERASE;
  assign wr_t_we = wr_ok && reg_addr == `FEPC_OFS_T_WERASE;
  assign wr_t_pg = wr_ok && reg_addr == `FEPC_OFS_T_PROG;

  // Unlock sequence: a stray write at any step sends it back to the start
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
      unl_state <= FEPC_UNL_IDLE;
    else if (reg_wr && hit_unlock)
    begin
      if (unl_state == FEPC_UNL_HALF &&
          reg_wdata[15:0] == `FEPC_UNLOCK_CODE2)
        unl_state <= FEPC_UNL_OPEN;
      else if (reg_wdata[15:0] == `FEPC_UNLOCK_CODE1)
        unl_state <= FEPC_UNL_HALF;
      else
        unl_state <= FEPC_UNL_IDLE;
    end
    else if (reg_wr || fl_wr)
      unl_state <= FEPC_UNL_IDLE;
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
    begin
      operation_select <= FEPC_OP_READ;
      alarm_irq_enables <= 2'h0;
    end
    else if (wr_ctrl)
    begin
      operation_select <= fepc_op_e'(reg_wdata[`FEPC_CTL_OP_LSB +: 2]);
      alarm_irq_enables <= reg_wdata[`FEPC_CTL_IE_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // Lock bits: zero after reset forbids every main-array erase and program
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
    begin
      lock_bits_low <= `FEPC_LOCK_RESET;
      lock_bits_high <= `FEPC_LOCK_RESET;
    end
    else
    begin
      if (wr_lock_lo)
        lock_bits_low <= reg_wdata;
      if (wr_lock_hi)
        lock_bits_high <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Values caught from the option and configuration area after full reset
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    cold_load <= rst;
  end

  // Boot select reloads only on a full reset, so a cleared bit survives
  // a CPU-only reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
      boot_loader_select_bit <= `FEPC_BOOT_RESET;
    else if (cold_load)
      boot_loader_select_bit <= user_option_word_boot;
    else if (wr_boot)
      boot_loader_select_bit <= reg_wdata[0];
  end

  // Timing values load themselves; software may still override them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sector_erase_time <= 32'h0;
      whole_erase_time <= 32'h0;
      program_time <= 32'h0;
    end
    else if (cold_load)
    begin
      sector_erase_time <= cfg_sector_erase_time;
      whole_erase_time <= cfg_whole_erase_time;
      program_time <= cfg_program_time;
    end
    else
    begin
      if (wr_t_se)
        sector_erase_time <= reg_wdata;
      if (wr_t_we)
        whole_erase_time <= reg_wdata;
      if (wr_t_pg)
        program_time <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Flash address decode and protection checks
  // ----------------------------------------------------------------------
  logic in_main;
  logic in_opt;
  logic in_cfg;
  logic [63:0] lock_all;
  logic pair_open;
  logic pc_in_main;
  logic pc_hit;
  logic lock_fail;
  logic target_ok;
  logic launch;

  assign in_main = fl_addr[31:`FEPC_MAIN_MSB+1] == `FEPC_MAIN_HI_ZERO;
  assign in_opt = fl_addr[31:`FEPC_SECTOR_LSB] == `FEPC_OPT_SECTOR;
  assign in_cfg = fl_addr[31:`FEPC_CFG_LSB] == `FEPC_CFG_WINDOW;
  assign lock_all = {lock_bits_high, lock_bits_low};
  // Two 512-byte sectors share one lock bit
  assign pair_open = lock_all[fl_addr[`FEPC_MAIN_MSB:`FEPC_PAIR_LSB]];
  assign pc_in_main = cpu_pc[31:`FEPC_MAIN_MSB+1] == `FEPC_MAIN_HI_ZERO;

  // Sector match on the bits above the 512-byte offset; a chip erase
  // targets every main sector, so any PC in the main array collides
  always_comb
  begin
    if (operation_select == FEPC_OP_WERASE)
      pc_hit = pc_in_main;
    else
      pc_hit = cpu_pc[31:`FEPC_SECTOR_LSB] ==
               fl_addr[31:`FEPC_SECTOR_LSB];
  end

  // Lock and range checks per operation; the configuration window and
  // anything outside the map never start an operation
  always_comb
  begin
    lock_fail = 1'b0;
    target_ok = 1'b0;
    case (operation_select)
      FEPC_OP_PROG, FEPC_OP_SERASE:
      begin
        target_ok = (in_main && pair_open) || in_opt;
        lock_fail = in_main && !pair_open;
      end
      FEPC_OP_WERASE:
      begin
        // Low 16 bits ignored: main array only, never the system region
        target_ok = in_main && lock_all == `FEPC_LOCK_ALL;
        lock_fail = in_main && lock_all != `FEPC_LOCK_ALL;
      end
      default:
      begin
        target_ok = 1'b0;
        lock_fail = 1'b0;
      end
    endcase
  end

  // Writes during busy are dropped; software is expected to poll first
  assign launch = fl_wr && seq_state == FEPC_SEQ_IDLE &&
                  operation_select != FEPC_OP_READ;
  assign timer_start = launch && target_ok && !pc_hit;

  // ----------------------------------------------------------------------
  // Sequencer: one timed array pulse per accepted write
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (operation_select)
      FEPC_OP_PROG: timer_len = program_time;
      FEPC_OP_SERASE: timer_len = sector_erase_time;
      default: timer_len = whole_erase_time;
    endcase
  end

  fepc_pulse_timer u_timer
  (
    .core_clk(core_clk),
    .rst(soft_rst),
    .start(timer_start),
    .length(timer_len),
    .active(timer_active),
    .done(timer_done)
  );

  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
      seq_state <= FEPC_SEQ_IDLE;
    else
      case (seq_state)
        FEPC_SEQ_IDLE:
          if (timer_start)
            seq_state <= FEPC_SEQ_RUN;
        FEPC_SEQ_RUN:
          if (timer_done)
            seq_state <= FEPC_SEQ_IDLE;
        default:
          seq_state <= FEPC_SEQ_IDLE;
      endcase
  end

  // Busy covers the whole pulse; fetches wait on a twin flop with the same next-state logic
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
    begin
      busy <= 1'b0;
      fetch_hold <= 1'b0;
    end
    else
    begin
      busy <= timer_start || (busy && !timer_done);
      fetch_hold <= timer_start || (busy && !timer_done);
    end
  end

  // Array command outputs, latched on timer_start and held through the pulse
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
    begin
      arr_prog <= 1'b0;
      arr_sector_erase <= 1'b0;
      arr_whole_erase <= 1'b0;
      arr_system_region <= 1'b0;
      arr_addr <= 32'h0;
      arr_wdata <= 32'h0;
      arr_size <= 2'h0;
    end
    else if (timer_start)
    begin
      arr_prog <= operation_select == FEPC_OP_PROG;
      arr_sector_erase <= operation_select == FEPC_OP_SERASE;
      arr_whole_erase <= operation_select == FEPC_OP_WERASE;
      arr_system_region <= in_opt;
      arr_addr <= fl_addr;
      // Chip erase data is meaningless, so it is not passed on
      arr_wdata <= operation_select == FEPC_OP_WERASE ? 32'h0 : fl_wdata;
      arr_size <= fl_size;
    end
    else if (timer_done)
    begin
      arr_prog <= 1'b0;
      arr_sector_erase <= 1'b0;
      arr_whole_erase <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Alarm flags: a new alarm wins over a clear in the same cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
    begin
      pc_alarm_flag <= 1'b0;
      lock_alarm_flag <= 1'b0;
    end
    else
    begin
      if (launch && pc_hit)
        pc_alarm_flag <= 1'b1;
      else if (wr_clear && !reg_wdata[`FEPC_FLAG_PC_BIT])
        pc_alarm_flag <= 1'b0;
      if (launch && lock_fail)
        lock_alarm_flag <= 1'b1;
      else if (wr_clear && !reg_wdata[`FEPC_FLAG_LOCK_BIT])
        lock_alarm_flag <= 1'b0;
    end
  end

  // Interrupt line, each flag gated by its own enable
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
      irq <= 1'b0;
    else
      irq <= (pc_alarm_flag && alarm_irq_enables[`FEPC_IE_PC_BIT]) ||
             (lock_alarm_flag && alarm_irq_enables[`FEPC_IE_LOCK_BIT]);
  end

  // ----------------------------------------------------------------------
  // Register reads: data in the cycle after the strobe, words only
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      if (reg_addr == `FEPC_OFS_CONTROL)
        reg_rdata <= {27'h0, alarm_irq_enables, busy, operation_select};
      else if (reg_addr == `FEPC_OFS_FLAGS)
        reg_rdata <= {30'h0, lock_alarm_flag, pc_alarm_flag};
      else if (reg_addr == `FEPC_OFS_LOCK_LO)
        reg_rdata <= lock_bits_low;
      else if (reg_addr == `FEPC_OFS_LOCK_HI)
        reg_rdata <= lock_bits_high;
      else if (reg_addr == `FEPC_OFS_BOOT)
        reg_rdata <= {31'h0, boot_loader_select_bit};
      else if (reg_addr == `FEPC_OFS_T_SERASE)
        reg_rdata <= sector_erase_time;
      else if (reg_addr == `FEPC_OFS_T_WERASE)
        reg_rdata <= whole_erase_time;
      else if (reg_addr == `FEPC_OFS_T_PROG)
        reg_rdata <= program_time;
      else
        reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Flash reads: the array answers the bus address at once, so the word
  // is returned in the next cycle like any memory read
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
      fl_rdata <= 32'h0;
    else if (fl_rd)
      fl_rdata <= (in_main || in_opt || in_cfg) ? arr_rdata : 32'h0;
  end

endmodule : fepc_top

// file: rtl/fepc_regs.svh
// Register offsets, field positions, codes and address map of the flash controller
`ifndef FEPC_REGS_SVH
`define FEPC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define FEPC_OFS_CONTROL 8'h00
`define FEPC_OFS_FLAGS 8'h04
`define FEPC_OFS_CLEAR 8'h08
`define FEPC_OFS_UNLOCK 8'h0c
`define FEPC_OFS_LOCK_LO 8'h10
`define FEPC_OFS_LOCK_HI 8'h14
`define FEPC_OFS_BOOT 8'h18
`define FEPC_OFS_T_SERASE 8'h1c
`define FEPC_OFS_T_WERASE 8'h20
`define FEPC_OFS_T_PROG 8'h24

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define FEPC_CTL_OP_LSB 0
`define FEPC_CTL_BUSY_BIT 2
`define FEPC_CTL_IE_LSB 3
`define FEPC_FLAG_PC_BIT 0
`define FEPC_FLAG_LOCK_BIT 1
`define FEPC_IE_PC_BIT 0
`define FEPC_IE_LOCK_BIT 1
`define FEPC_UNLOCK_CODE1 16'h5a5a
`define FEPC_UNLOCK_CODE2 16'ha5a5
`define FEPC_LOCK_RESET 32'h0000_0000
`define FEPC_LOCK_ALL 64'hffff_ffff_ffff_ffff
`define FEPC_BOOT_RESET 1'b1

// ----------------------------------------------------------------------
// Address map: main array, option sector, configuration window
// ----------------------------------------------------------------------
`define FEPC_MAIN_HI_ZERO 16'h0000
`define FEPC_OPT_SECTOR 23'h04_0000
`define FEPC_CFG_WINDOW 24'h18_0000
`define FEPC_CFG_LSB 8
`define FEPC_SECTOR_LSB 9
`define FEPC_PAIR_LSB 10
`define FEPC_CHIP_LSB 15
`define FEPC_MAIN_MSB 15

`endif

// file: rtl/fepc_pkg.sv
// Types shared by the flash controller modules
package fepc_pkg;

  // Operation selected for the next flash write
  typedef enum logic [1:0]
  {
    FEPC_OP_READ = 2'h0,
    FEPC_OP_PROG = 2'h1,
    FEPC_OP_SERASE = 2'h2,
    FEPC_OP_WERASE = 2'h3
  } fepc_op_e;

  // Register unlock progress
  typedef enum logic [1:0]
  {
    FEPC_UNL_IDLE,
    FEPC_UNL_HALF,
    FEPC_UNL_OPEN
  } fepc_unlock_e;

  // Flash operation sequencer
  typedef enum logic
  {
    FEPC_SEQ_IDLE,
    FEPC_SEQ_RUN
  } fepc_seq_e;

endpackage : fepc_pkg

// file: rtl/fepc_pulse_timer.sv
// Down-counter that times one erase or program pulse
`timescale 1ns/1ps
module fepc_pulse_timer
  import fepc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] length,
  output logic active,
  output logic done
);

  logic [31:0] remain;

  // ----------------------------------------------------------------------
  // Count the pulse; a zero length still lasts one cycle. Done stands in
  // the last cycle, so a caller that drops its strobe on done keeps the
  // strobe for exactly the programmed number of cycles.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      remain <= 32'h0;
      active <= 1'b0;
      done <= 1'b0;
    end
    else if (start && !active)
    begin
      remain <= (length == 32'h0) ? 32'h0 : length - 32'h1;
      active <= 1'b1;
      done <= length <= 32'h1;
    end
    else if (active)
    begin
      remain <= (remain == 32'h0) ? 32'h0 : remain - 32'h1;
      active <= remain != 32'h0;
      done <= remain == 32'h1;
    end
    else
      done <= 1'b0;
  end

endmodule : fepc_pulse_timer

// file: verification/fepc_top_properties.sv
// Port-level assertions for the flash controller top
`timescale 1ns/1ps
module fepc_top_properties
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic fl_wr,
  input wire logic fl_rd,
  input wire logic [31:0] fl_addr,
  input wire logic [31:0] fl_rdata,
  input wire logic [31:0] cpu_pc,
  input wire logic user_option_word_boot,
  input wire logic [31:0] arr_rdata,
  input wire logic arr_prog,
  input wire logic arr_sector_erase,
  input wire logic arr_whole_erase,
  input wire logic arr_system_region,
  input wire logic [31:0] arr_wdata,
  input wire logic fetch_hold,
  input wire logic boot_loader_select_bit,
  input wire logic irq
);
  // --------
  // Checks, all in the core clock domain
  // --------
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_hold_strobe: assert property ((arr_prog | arr_sector_erase |
    arr_whole_erase) |-> fetch_hold) else $error("strobe without hold");
  a_hold_cause: assert property ($rose(fetch_hold) |-> $past(fl_wr))
    else $error("busy without flash write");
  a_one_op: assert property ($onehot0({arr_prog, arr_sector_erase,
    arr_whole_erase})) else $error("two array strobes");
  a_whole_main: assert property (arr_whole_erase |-> !arr_system_region)
    else $error("chip erase hits system region");
  a_whole_data: assert property ($rose(arr_whole_erase) |->
    arr_wdata == 32'h0) else $error("chip erase data not ignored");
  // Same-sector write from running code never starts an operation
  a_pc_block: assert property (fl_wr && !fetch_hold &&
    fl_addr[31:16] == 16'h0 && fl_addr[31:9] == cpu_pc[31:9]
    |=> !fetch_hold[*3]) else $error("pc sector not blocked");
  a_cfg_ro: assert property (fl_wr && !fetch_hold &&
    fl_addr[31:8] == 24'h180000 |=> !fetch_hold)
    else $error("config window erased");
  a_read_data: assert property (fl_rd && fl_addr[31:16] == 16'h0
    |=> fl_rdata == $past(arr_rdata)) else $error("flash read data");
  a_irq_cause: assert property ($rose(irq) |->
    $past(fl_wr, 2) || $past(reg_wr, 2)) else $error("irq without cause");
  a_boot_load: assert property ($fell(rst) |-> ##2
    boot_loader_select_bit == $past(user_option_word_boot, 2))
    else $error("boot select not loaded");
endmodule : fepc_top_properties

bind fepc_top fepc_top_properties u_props (.core_clk, .rst, .reg_wr,
  .fl_wr, .fl_rd, .fl_addr, .fl_rdata, .cpu_pc, .user_option_word_boot,
  .arr_rdata, .arr_prog, .arr_sector_erase, .arr_whole_erase,
  .arr_system_region, .arr_wdata, .fetch_hold, .boot_loader_select_bit,
  .irq);

// file: verification/fepc_cpu_model.sv
// CPU bus master model driving the register port and flash stores
`timescale 1ns/1ps
module fepc_cpu_model
(
  input wire logic core_clk,
  input wire logic busy,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic fl_wr,
  output logic fl_rd,
  output logic [31:0] fl_addr,
  output logic [31:0] fl_wdata
);
  // Idle bus at time zero; timing registers are never written
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    {reg_wr, reg_rd, fl_wr, fl_rd} = 4'h0;
    fl_addr = 32'h0;
    fl_wdata = 32'h0;
  end

  // Word-wide register write; data inverted once released
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // Unlock codes back to back, then one write
  task uw(input logic [7:0] a, input logic [31:0] d);
    wr(8'h0c, 32'h5a5a);
    wr(8'h0c, 32'ha5a5);
    wr(a, d);
  endtask : uw

  // Register read strobe; data is taken by the bench monitor
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Flash store, which launches the selected operation
  task fw(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    fl_addr <= a;
    fl_wdata <= d;
    fl_wr <= 1'b1;
    @(posedge core_clk);
    fl_wr <= 1'b0;
    fl_wdata <= ~d;
  endtask : fw

  // Flash load
  task fr(input logic [31:0] a);
    @(posedge core_clk);
    fl_addr <= a;
    fl_rd <= 1'b1;
    @(posedge core_clk);
    fl_rd <= 1'b0;
  endtask : fr

  // Code in RAM polls busy before anything else
  task poll(output logic ok);
    ok = 1'b0;
    repeat (60)
    begin
      @(posedge core_clk);
      if (busy === 1'b0)
      begin
        ok = 1'b1;
        break;
      end
    end
  endtask : poll
endmodule : fepc_cpu_model

// file: verification/fepc_top_tb.sv
// Self-checking bench for the flash controller
`timescale 1ns/1ps
module fepc_top_tb;
  logic core_clk, rst, cpu_only_reset, reg_wr, reg_rd, fl_wr, fl_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fl_addr, fl_wdata, fl_rdata;
  logic [31:0] cpu_pc, arr_rdata, a, plen;
  logic [31:0] cfg_se, cfg_we, cfg_pg, arr_addr, arr_wdata;
  logic [1:0] fl_size, arr_size;
  logic arr_prog, arr_sector_erase, arr_whole_erase, arr_system_region;
  logic fetch_hold, boot_loader_select_bit, irq, rd_d, fd_d;
  logic user_option_word_boot;
  logic [31:0] rq[$];
  logic [31:0] pq[$];
  int n_mismatch, checks_done, seed;

  // Array answers with an address-derived pattern
  assign arr_rdata = {fl_addr[15:0], ~fl_addr[15:0]};

  fepc_top u_dut (.core_clk, .rst, .cpu_only_reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .fl_wr, .fl_rd, .fl_addr, .fl_wdata,
    .fl_size, .fl_rdata, .cpu_pc, .user_option_word_boot,
    .cfg_sector_erase_time(cfg_se), .cfg_whole_erase_time(cfg_we),
    .cfg_program_time(cfg_pg), .arr_rdata, .arr_prog, .arr_sector_erase,
    .arr_whole_erase, .arr_system_region, .arr_addr, .arr_wdata,
    .arr_size, .fetch_hold, .boot_loader_select_bit, .irq);

  fepc_cpu_model u_cpu (.core_clk, .busy(fetch_hold), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .fl_wr, .fl_rd, .fl_addr, .fl_wdata);

  // 200 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task rdx(input logic [7:0] ad, input logic [31:0] e);
    rq.push_back(e);
    u_cpu.rd(ad);
  endtask : rdx

  task idle;
    logic ok;
    u_cpu.poll(ok);
    if (!ok)
    begin
      n_mismatch++;
      end_of_test;
    end
  endtask : idle

  // Store, note the pulse length expected (0: none), wait for idle, then
  // check what the array was handed; only chip erase uses the 5 length
  task op(input logic [31:0] ad, input logic [31:0] n);
    logic [31:0] d;
    d = $random(seed);
    fl_size <= 2'($random(seed));
    if (n != 32'h0)
      pq.push_back(n);
    u_cpu.fw(ad, d);
    idle;
    if (n != 32'h0)
    begin
      chk(arr_addr, ad);
      chk(arr_wdata, (n == cfg_we) ? 32'h0 : d);
      chk({30'h0, arr_size}, {30'h0, fl_size});
    end
  endtask : op

  // Monitor: read data in the cycle after the strobe, pulse lengths
  always @(posedge core_clk)
  begin
    if (rd_d)
      chk(reg_rdata, rq.pop_front());
    if (fd_d)
      chk(fl_rdata, rq.pop_front());
    if (arr_prog | arr_sector_erase | arr_whole_erase)
      plen <= plen + 32'h1;
    else if (plen != 32'h0)
    begin
      chk(plen, pq.pop_front());
      plen <= 32'h0;
    end
    rd_d <= reg_rd;
    fd_d <= fl_rd;
  end

  // Main sequence
  initial
  begin
    {rst, cpu_only_reset, user_option_word_boot} = 3'h5;
    {rd_d, fd_d, plen, cpu_pc} = {2'h0, 32'h0, 32'h2000_0000};
    {cfg_se, cfg_we, cfg_pg, fl_size} = {32'h4, 32'h5, 32'h3, 2'h2};
    seed = 32'h2652;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rdx(8'h00, 32'h0);
    rdx(8'h04, 32'h0);
    rdx(8'h14, 32'h0);
    rdx(8'h18, 32'h1);
    rdx(8'h40, 32'h0);
    u_cpu.wr(8'h10, 32'hffff_ffff);
    rdx(8'h10, 32'h0);
    u_cpu.wr(8'h0c, 32'h5a5a);
    u_cpu.wr(8'h10, 32'h1);
    u_cpu.wr(8'h0c, 32'ha5a5);
    u_cpu.wr(8'h10, 32'hffff_ffff);
    rdx(8'h10, 32'h0);
    u_cpu.uw(8'h10, 32'h1);
    u_cpu.wr(8'h10, 32'h3);
    rdx(8'h10, 32'h1);
    u_cpu.uw(8'h00, 32'h1d);
    pq.push_back(32'h3);
    u_cpu.fw(32'h200, 32'h0);
    rdx(8'h00, 32'h1d);
    idle;
    op(32'h400, 32'h0);
    rdx(8'h04, 32'h2);
    chk({31'h0, irq}, 32'h1);
    u_cpu.uw(8'h08, 32'hffff_ffff);
    rdx(8'h04, 32'h2);
    u_cpu.uw(8'h08, 32'hffff_fffd);
    rdx(8'h04, 32'h0);
    cpu_pc <= 32'h204;
    op(32'h208, 32'h0);
    rdx(8'h04, 32'h1);
    u_cpu.uw(8'h00, 32'h13);
    rdx(8'h00, 32'h13);
    chk({31'h0, irq}, 32'h0);
    u_cpu.uw(8'h08, 32'hffff_fffe);
    cpu_pc <= 32'h2000_0000;
    op(32'h6abc, 32'h0);
    rdx(8'h04, 32'h2);
    u_cpu.uw(8'h08, 32'hffff_fffd);
    u_cpu.uw(8'h10, 32'hffff_ffff);
    u_cpu.uw(8'h14, 32'hffff_ffff);
    op(32'h6abc, 32'h5);
    u_cpu.uw(8'h00, 32'h2);
    op(32'h600, 32'h4);
    op(32'h0800_0000, 32'h4);
    op(32'h1800_0000, 32'h0);
    u_cpu.uw(8'h00, 32'h18);
    op(32'h200, 32'h0);
    rdx(8'h04, 32'h0);
    repeat (4)
    begin
      a = {16'h0, 16'($random(seed)) & 16'hfffc};
      rq.push_back({a[15:0], ~a[15:0]});
      u_cpu.fr(a);
    end
    rq.push_back(32'h0010_ffef);
    u_cpu.fr(32'h1800_0010);
    rq.push_back(32'h0);
    u_cpu.fr(32'h3000_0000);
    u_cpu.uw(8'h18, 32'h0);
    cpu_only_reset <= 1'b1;
    @(posedge core_clk);
    cpu_only_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    rdx(8'h18, 32'h0);
    rdx(8'h00, 32'h0);
    // Boot bit set by software, option bit low: a full reset must reload
    u_cpu.uw(8'h18, 32'h1);
    user_option_word_boot <= 1'b0;
    cfg_pg <= 32'h6;
    rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rdx(8'h18, 32'h0);
    rdx(8'h24, 32'h6);
    rdx(8'h10, 32'h0);
    repeat (3) @(posedge core_clk);
    end_of_test;
  end
endmodule : fepc_top_tb
